//--- hw/dcpr_pattern_readout.sv
// device-side command decoder with calibration pattern readout and array access
// Function
// - enabled reads come from the pattern register
// - location 00 gives pattern, others reserved
// - bit2 clear means normal array reads and writes
// - autoprecharge read behaves as plain read
// - reset input still honoured while enabled
// - both lanes carry pattern bit, rest repeat/zero
// - only bit two and chop used, bits 1..0 ignored
// - full order 0-7, chop halves by bit2
// - on-the-fly chop selected by address bit12
// - beat zero is pattern least significant bit
// - pattern alternates zero and one, starting zero
// - pattern reads use normal read latency
`timescale 1ns/1ps
module dcpr_pattern_readout
    import dcpr_pkg::*;
#(
    parameter int MRS_GAP_NCK = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dram_reset_n_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [BA_W-1:0] ba_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic autoprecharge_o,
    output logic pattern_mode_o
);
    localparam logic [3:0] GAP_INIT = 4'(MRS_GAP_NCK);

    // ------------------------------------------------------------
    // reset pin synchroniser and filter
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] rsync_q;
    logic pin_rst_q, pin_rst_d, rst_all;

    always_comb
    begin
        pin_rst_d = pin_rst_q;
        if (rsync_q[1] == rsync_q[2])
        begin
            pin_rst_d = ~rsync_q[2];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rsync_q <= '1;
            pin_rst_q <= 1'b0;
        end
        else
        begin
            rsync_q <= {rsync_q[1:0], dram_reset_n_i};
            pin_rst_q <= pin_rst_d;
        end
    end

    // the pin reset clears mode state even while readout is enabled
    assign rst_all = rst_i | pin_rst_q;

    // ------------------------------------------------------------
    // command decode and mode registers
    // ------------------------------------------------------------
    dcpr_state_t st_q, st_d;
    logic [8:0] ctrl_q, ctrl_d;
    logic mr3_en_q, mr3_en_d;
    logic [1:0] mr3_loc_q, mr3_loc_d, mr0_bl_q, mr0_bl_d;
    logic [3:0] gap_q, gap_d, rl_eff, wl_eff;
    logic [2:0] cmd;
    logic accept, mrs_take, rd_take, wr_take, chop_sel, ap_d, ap_q;
    logic [2:0] base_sel;

    assign cmd = {ras_n_i, cas_n_i, we_n_i};
    // commands arriving during a burst or the mode set gap are dropped
    assign accept = (st_q == ST_IDLE) && (gap_q == 4'h0) && !cs_n_i;
    assign mrs_take = accept && (cmd == CMD_MRS);
    assign rd_take = accept && (cmd == CMD_RD);
    // writes are not served in readout mode
    assign wr_take = accept && (cmd == CMD_WR) && !mr3_en_q;
    assign rl_eff = (ctrl_q[CTRL_RL_LSB +: 4] < RL_MIN) ? RL_MIN : ctrl_q[CTRL_RL_LSB +: 4];
    assign wl_eff = (ctrl_q[CTRL_WL_LSB +: 4] < WL_MIN) ? WL_MIN : ctrl_q[CTRL_WL_LSB +: 4];

    always_comb
    begin
        unique case (mr0_bl_q)
            BL_OTF: chop_sel = !addr_i[A_CHOP];
            BL_FIXED4: chop_sel = 1'b1;
            default: chop_sel = 1'b0;
        endcase
        // bank, column 9..3 are dropped for pattern reads, bits 1..0 never steer order
        base_sel = chop_sel ? {addr_i[A_NIBBLE], 2'b00} : 3'h0;
    end

    always_comb
    begin
        mr3_en_d = mr3_en_q;
        mr3_loc_d = mr3_loc_q;
        mr0_bl_d = mr0_bl_q;
        gap_d = (gap_q != 4'h0) ? gap_q - 4'h1 : gap_q;
        // autoprecharge only in normal mode; in readout mode a read stays a read
        ap_d = (rd_take || wr_take) && addr_i[A_AP] && !mr3_en_q;
        if (mrs_take)
        begin
            gap_d = GAP_INIT;
            if (ba_i == MR_THREE)
            begin
                mr3_en_d = addr_i[A_PAT_EN];
                mr3_loc_d = addr_i[1:0];
            end
            else if (ba_i == MR_ZERO)
            begin
                mr0_bl_d = addr_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            mr3_en_q <= 1'b0;
            mr3_loc_q <= LOC_PREDEF;
            mr0_bl_q <= BL_FIXED8;
            gap_q <= 4'h0;
            ap_q <= 1'b0;
        end
        else
        begin
            mr3_en_q <= mr3_en_d;
            mr3_loc_q <= mr3_loc_d;
            mr0_bl_q <= mr0_bl_d;
            gap_q <= gap_d;
            ap_q <= ap_d;
        end
    end

    // ------------------------------------------------------------
    // burst engine
    // ------------------------------------------------------------
    logic [3:0] dly_q, dly_d;
    logic [2:0] cnt_q, cnt_d, base_q, base_d, beat;
    logic chop_q, chop_d, wr_q, wr_d, pat_q, pat_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [BA_W-1:0] ba_q, ba_d;
    logic [MEM_AW-1:0] mem_addr;
    logic [DQ_W-1:0] mem_rdata;
    logic mem_we;

    assign beat = base_q + cnt_q;
    assign mem_addr = {ba_q, col_q, beat};
    assign mem_we = (st_q == ST_BURST) && wr_q;

    always_comb
    begin
        st_d = st_q;
        dly_d = dly_q;
        cnt_d = cnt_q;
        base_d = base_q;
        chop_d = chop_q;
        wr_d = wr_q;
        pat_d = pat_q;
        col_d = col_q;
        ba_d = ba_q;
        unique case (st_q)
            ST_IDLE:
            begin
                if (rd_take || wr_take)
                begin
                    st_d = ST_WAIT;
                    // same latency path for array and pattern reads
                    dly_d = rd_take ? rl_eff - RL_MIN : wl_eff - WL_MIN;
                    cnt_d = 3'h0;
                    base_d = base_sel;
                    chop_d = chop_sel;
                    wr_d = wr_take;
                    pat_d = rd_take && mr3_en_q;
                    col_d = addr_i[COL_LSB +: COL_W];
                    ba_d = ba_i;
                end
            end
            ST_WAIT:
            begin
                if (dly_q == 4'h0)
                begin
                    st_d = ST_BURST;
                end
                else
                begin
                    dly_d = dly_q - 4'h1;
                end
            end
            ST_BURST:
            begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == (chop_q ? LAST_CHOP : LAST_FULL))
                begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            st_q <= ST_IDLE;
            dly_q <= 4'h0;
            cnt_q <= 3'h0;
            base_q <= 3'h0;
            chop_q <= 1'b0;
            wr_q <= 1'b0;
            pat_q <= 1'b0;
            col_q <= '0;
            ba_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            dly_q <= dly_d;
            cnt_q <= cnt_d;
            base_q <= base_d;
            chop_q <= chop_d;
            wr_q <= wr_d;
            pat_q <= pat_d;
            col_q <= col_d;
            ba_q <= ba_d;
        end
    end

    dcpr_array_mem #(
        .DW(DQ_W),
        .AW(MEM_AW)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(mem_addr),
        .wdata_i(dq_i),
        .raddr_i(mem_addr),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------
    // read data pipeline, aligned with the array's read register
    // ------------------------------------------------------------
    logic rv_q, rv_d, rpat_q, rpat_d, rbit_q, rbit_d, opat_q, oe_q;
    logic [DQ_W-1:0] dq_q, dq_d;
    logic [LANE_W-2:0] fill;

    assign fill = ctrl_q[CTRL_FILL_BIT] ? '0 : {(LANE_W-1){rbit_q}};

    always_comb
    begin
        rv_d = (st_q == ST_BURST) && !wr_q;
        rpat_d = pat_q;
        // reserved locations read as zero
        rbit_d = (mr3_loc_q == LOC_PREDEF) ? PATTERN_PREDEF[beat] : 1'b0;
        dq_d = '0;
        if (rv_q)
        begin
            dq_d = rpat_q ? {fill, rbit_q, fill, rbit_q} : mem_rdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            rv_q <= 1'b0;
            rpat_q <= 1'b0;
            rbit_q <= 1'b0;
            dq_q <= '0;
            oe_q <= 1'b0;
            opat_q <= 1'b0;
        end
        else
        begin
            rv_q <= rv_d;
            rpat_q <= rpat_d;
            rbit_q <= rbit_d;
            dq_q <= dq_d;
            oe_q <= rv_q;
            opat_q <= rv_q && rpat_q;
        end
    end

    assign dq_o = dq_q;
    assign dq_oe_o = oe_q;
    assign autoprecharge_o = ap_q;
    assign pattern_mode_o = mr3_en_q;

    // ------------------------------------------------------------
    // wishbone slave, one wait state, unmapped reads zero
    // ------------------------------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;

    always_comb
    begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        ctrl_d = ctrl_q;
        rdat_d = 32'h0000_0000;
        if (ack_d && (wb_adr_i == REG_CTRL))
        begin
            rdat_d = {23'h0, ctrl_q};
            if (wb_we_i && wb_sel_i[0])
            begin
                ctrl_d[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1])
            begin
                ctrl_d[CTRL_FILL_BIT] = wb_dat_i[CTRL_FILL_BIT];
            end
        end
        else if (ack_d && (wb_adr_i == REG_STAT))
        begin
            rdat_d = {25'h0, gap_q != 4'h0, st_q != ST_IDLE, mr0_bl_q, mr3_loc_q, mr3_en_q};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            ctrl_q <= ctrl_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [3:0] lat_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_all || rd_take)
        begin
            lat_q <= rd_take ? 4'h1 : 4'h0;
        end
        else if (lat_q != 4'h0 && lat_q != 4'hF)
        begin
            lat_q <= lat_q + 4'h1;
        end
    end

    sequence s_pat_rd;
        rd_take && mr3_en_q;
    endsequence
    sequence s_alt4;
        !dq_o[0] ##1 dq_o[0] ##1 !dq_o[0] ##1 dq_o[0];
    endsequence
    sequence s_chop_go;
        st_q == ST_WAIT && dly_q == 4'h0 && chop_q;
    endsequence

    property p_pat_src;
        @(posedge clk_i) disable iff (rst_all) s_pat_rd |=> pat_q && !wr_q;
    endproperty
    a_pat_src: assert property (p_pat_src) else $error("pattern read not redirected");
    property p_normal;
        @(posedge clk_i) disable iff (rst_all) rd_take && !mr3_en_q |=> !pat_q;
    endproperty
    a_normal: assert property (p_normal) else $error("array read flagged as pattern");
    property p_no_ap;
        @(posedge clk_i) disable iff (rst_all) s_pat_rd |=> !autoprecharge_o;
    endproperty
    a_no_ap: assert property (p_no_ap) else $error("autoprecharge in readout mode");
    property p_pin_rst;
        @(posedge clk_i) disable iff (rst_i) pin_rst_q |=> !mr3_en_q && st_q == ST_IDLE;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("reset pin ignored");
    logic [LANE_W-2:0] fill_o_chk;
    assign fill_o_chk = (ctrl_q[CTRL_FILL_BIT] || !dq_o[0]) ? '0 : '1;
    property p_lanes;
        @(posedge clk_i) disable iff (rst_all)
            opat_q |-> dq_o[LANE_W-1:0] == dq_o[DQ_W-1:LANE_W] && dq_o[LANE_W-1:1] == fill_o_chk;
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane fill wrong");
    property p_alt;
        @(posedge clk_i) disable iff (rst_all)
            $rose(opat_q) && mr3_loc_q == LOC_PREDEF |-> s_alt4;
    endproperty
    a_alt: assert property (p_alt) else $error("pattern not alternating from zero");
    property p_rsvd;
        @(posedge clk_i) disable iff (rst_all)
            opat_q && mr3_loc_q != LOC_PREDEF |-> dq_o == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved location not zero");
    property p_chop_len;
        @(posedge clk_i) disable iff (rst_all) s_chop_go |=> (st_q == ST_BURST) [*4] ##1 st_q == ST_IDLE;
    endproperty
    a_chop_len: assert property (p_chop_len) else $error("chopped burst not four beats");
    property p_nibble;
        @(posedge clk_i) disable iff (rst_all)
            s_pat_rd |=> base_q == (chop_q ? {$past(addr_i[A_NIBBLE]), 2'b00} : 3'h0);
    endproperty
    a_nibble: assert property (p_nibble) else $error("burst start wrong");
    property p_otf;
        @(posedge clk_i) disable iff (rst_all)
            s_pat_rd and mr0_bl_q == BL_OTF |=> chop_q == !$past(addr_i[A_CHOP]);
    endproperty
    a_otf: assert property (p_otf) else $error("chop select ignored");
    property p_latency;
        @(posedge clk_i) disable iff (rst_all) $rose(dq_oe_o) |-> lat_q == rl_eff;
    endproperty
    a_latency: assert property (p_latency) else $error("read latency wrong");
    property p_gap;
        @(posedge clk_i) disable iff (rst_all)
            mrs_take && ba_i == MR_THREE && !addr_i[A_PAT_EN] |=> !mr3_en_q && !accept;
    endproperty
    a_gap: assert property (p_gap) else $error("mode set gap not kept");
endmodule // dcpr_pattern_readout

//--- hw/dcpr_pkg.sv
// constants, register map and state type for the calibration pattern readout block
package dcpr_pkg;
    // ------------------------------------------------------------
    // command pins and address bits
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int BA_W = 3;
    localparam int DQ_W = 16;
    localparam int LANE_W = 8;
    localparam int COL_LSB = 3;
    localparam int COL_W = 7;
    localparam int MEM_AW = BA_W + COL_W + 3;
    // command code is {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] MR_ZERO = 3'h0;
    localparam logic [2:0] MR_THREE = 3'h3;
    localparam int A_PAT_EN = 2;
    localparam int A_NIBBLE = 2;
    localparam int A_AP = 10;
    localparam int A_CHOP = 12;
    // mode register zero burst field
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    // pattern source select and contents, beat 0 is bit 0
    localparam logic [1:0] LOC_PREDEF = 2'h0;
    localparam logic [7:0] PATTERN_PREDEF = 8'hAA;
    localparam logic [2:0] LAST_FULL = 3'h7;
    localparam logic [2:0] LAST_CHOP = 3'h3;
    // ------------------------------------------------------------
    // wishbone register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int CTRL_RL_LSB = 0;
    localparam int CTRL_WL_LSB = 4;
    localparam int CTRL_FILL_BIT = 8;
    localparam logic [8:0] CTRL_RESET = 9'h045;
    localparam logic [3:0] RL_MIN = 4'h4;
    localparam logic [3:0] WL_MIN = 4'h2;
    localparam int SYNC_STAGES = 3;
    // ------------------------------------------------------------
    // burst engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BURST = 3'b100
    } dcpr_state_t;
endpackage

//--- hw/dcpr_array_mem.sv
// memory array model with one write port and a registered read port
`timescale 1ns/1ps
module dcpr_array_mem #(
    parameter int DW = 16,
    parameter int AW = 13
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule // dcpr_array_mem

//--- bench/dcpr_ctrl_model.sv
// controller model driving command pins and write data of the readout block
`timescale 1ns/1ps
module dcpr_ctrl_model
    import dcpr_pkg::*;
(
    input wire logic clk_i,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [BA_W-1:0] ba_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DQ_W-1:0] dq_o
);
    // ----------------------------------------
    // command tasks, entered just after a rising edge
    // ----------------------------------------
    initial
    begin
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
        ba_o = 3'h0;
        addr_o = 13'h0000;
        dq_o = 16'h0000;
    end
    // only what a scenario asks for: no activate, refresh or power-down ever
    task automatic cmd(input logic [2:0] code, input logic [BA_W-1:0] ba,
                       input logic [ADDR_W-1:0] a);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {1'b0, code};
        ba_o <= ba;
        addr_o <= (code == CMD_RD) ? {a[ADDR_W-1:2], 2'h0} : a;
        @(posedge clk_i);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hF;
        // inverted so a stale address never passes for a live one
        ba_o <= ~ba;
        addr_o <= ~a;
    endtask
    task automatic mode_register_set_command(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a);
        cmd(CMD_MRS, ba, a);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wr(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a,
                      input logic [DQ_W-1:0] base, input int wl);
        cmd(CMD_WR, ba, a);
        repeat (wl - 1) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            dq_o <= base + DQ_W'(i * 32'h1111);
            @(posedge clk_i);
        end
        dq_o <= ~dq_o;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // dcpr_ctrl_model

//--- bench/dcpr_pattern_readout_tb.sv
// self-checking bench: register access, array traffic and pattern reads
`timescale 1ns/1ps
module dcpr_pattern_readout_tb;
    import dcpr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic dram_reset_n_i = 1'b1;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cs_n, ras_n, cas_n, we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_w;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe_o;
    logic autoprecharge_o;
    logic pattern_mode_o;
    logic ap_seen;
    logic [31:0] q;
    logic [15:0] exp_q [8];
    int bad_count = 0;
    int checks = 0;
    // ----------------------------------------
    // clock, design and controller model
    // ----------------------------------------
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    dcpr_pattern_readout #(.MRS_GAP_NCK(4)) dcpr_pattern_readout_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dram_reset_n_i(dram_reset_n_i),
        .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
        .addr_i(addr), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
        .autoprecharge_o(autoprecharge_o), .pattern_mode_o(pattern_mode_o));
    dcpr_ctrl_model ctrl_inst (
        .clk_i(clk_i), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
        .ba_o(ba), .addr_o(addr), .dq_o(dq_w));
    // ----------------------------------------
    // checking and access tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      input logic [3:0] sel);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        chk("wb ack wait", 1, n < 20);
        if (n >= 20)
            end_sim();
    endtask
    // outputs are read at each edge before that edge's updates land, as the controller
    // would sample them, so k counts the edge at which the first beat is taken
    task automatic rd(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input int n,
                      input int rl);
        int k;
        k = 0;
        ap_seen = 1'b0;
        ctrl_inst.cmd(CMD_RD, b, a);
        do
        begin
            @(posedge clk_i);
            k++;
            ap_seen = ap_seen | autoprecharge_o;
        end
        while (dq_oe_o !== 1'b1 && k < 20);
        chk("read latency", rl, k);
        if (k >= 20)
            end_sim();
        for (int i = 0; i < n; i++)
        begin
            chk("read beat", exp_q[i], dq_o);
            @(posedge clk_i);
        end
        chk("oe after burst", 0, dq_oe_o);
        @(posedge clk_i);
    endtask
    task automatic set_pat(input int n, input logic zf, input logic on);
        for (int i = 0; i < 8; i++)
            exp_q[i] = (on && i < n) ? (zf ? {2{7'h00, i[0]}} : {16{i[0]}}) : 16'h0;
    endtask
    task automatic set_arr();
        for (int i = 0; i < 8; i++)
            exp_q[i] = 16'h1234 + 16'(i * 32'h1111);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb(1'b0, REG_CTRL, 32'h0, 4'hF);
        chk("ctrl reset", 32'h045, q);
        wb(1'b0, REG_STAT, 32'h0, 4'hF);
        chk("stat reset", 32'h0, q);
        wb(1'b1, 8'h08, 32'hFFFFFFFF, 4'hF);
        wb(1'b0, 8'h08, 32'h0, 4'hF);
        chk("unmapped read", 32'h0, q);
        ctrl_inst.mode_register_set_command(3'h3, 13'h0003);
        ctrl_inst.wr(3'h1, 13'h0018, 16'h1234, 4);
        set_arr();
        rd(3'h1, 13'h0418, 8, 5);
        chk("array autoprecharge", 1, ap_seen);
        ctrl_inst.mode_register_set_command(3'h0, 13'h0001);
        ctrl_inst.mode_register_set_command(3'h3, 13'h0004);
        chk("pattern mode", 1, pattern_mode_o);
        wb(1'b0, REG_STAT, 32'h0, 4'hF);
        chk("stat enabled", 32'h09, q);
        // every ignored address field but bits 2..0 set: column, autoprecharge and bit 11, with bank 5
        set_pat(8, 1'b0, 1'b1);
        rd(3'h5, 13'h1FF8, 8, 5);
        chk("pattern autoprecharge", 0, ap_seen);
        set_pat(4, 1'b0, 1'b1);
        rd(3'h2, 13'h0000, 4, 5);
        rd(3'h6, 13'h0004, 4, 5);
        wb(1'b1, REG_CTRL, 32'h146, 4'h3);
        set_pat(8, 1'b1, 1'b1);
        rd(3'h0, 13'h1000, 8, 6);
        wb(1'b1, REG_CTRL, 32'h045, 4'h3);
        set_pat(8, 1'b0, 1'b0);
        for (int loc = 1; loc < 4; loc++)
        begin
            ctrl_inst.mode_register_set_command(3'h3, 13'h0004 | 13'(loc));
            rd(3'h0, 13'h1000, 8, 5);
        end
        ctrl_inst.mode_register_set_command(3'h3, 13'h0000);
        set_arr();
        rd(3'h1, 13'h1018, 8, 5);
        ctrl_inst.mode_register_set_command(3'h3, 13'h0004);
        dram_reset_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("mode after reset pin", 0, pattern_mode_o);
        dram_reset_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("mode after pin release", 0, pattern_mode_o);
        set_arr();
        rd(3'h1, 13'h1018, 8, 5);
        end_sim();
    end
endmodule // dcpr_pattern_readout_tb
